//--- hdl/rcr_top.sv
// Remote code receiver top: register slave, frame matcher, window logic and open-drain output.
`timescale 1ns/1ps
`include "rcr_cfg.svh"
module rcr_top #(
  parameter int AXI_ADDR_W = 12
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  code_in_pin,
  input  wire logic                  time_pin,
  output logic                       out_pin_o,
  output logic                       out_pin_oe
);
  import rcr_pkg::*;

  if (AXI_ADDR_W < 4)
  begin : g_chk
    $error("AXI_ADDR_W must be at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [31:0]           stored_reg, stored_next, timing_reg, timing_next;
  logic                  aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [AXI_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0]           wdata_reg, wdata_next;
  logic [3:0]            wstrb_reg, wstrb_next;
  logic                  bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]            bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]           rdata_reg, rdata_next, status_w;
  logic [15:0]           div_reg, div_next;
  logic                  osc_tick;
  logic [1:0]            pins_sync;
  logic [24:0]           shift_reg, shift_next;
  logic [4:0]            nbit_reg, nbit_next;
  logic                  match_reg, match_next, matched_last_reg, matched_last_next;
  logic                  win_reg, win_next, win_end;
  logic [3:0]            count_reg, count_next, need;
  logic                  toggle_reg, toggle_next;
  rcr_out_state_t        st_reg, st_next;
  logic [21:0]           cnt_reg, cnt_next, len;
  logic                  drive_low_reg, drive_low_next;
  logic                  rx_on, want_high;
  rcr_kind_t             kind;
  rcr_sym_if             sym ();

  ////////////////////////////////////////////////////////////////////////////////
  // Receive role check
  assign rx_on = !stored_reg[`RCR_BIT_ROLE] && !stored_reg[`RCR_BIT_TX_REPEAT];
  assign kind  = rcr_kind_t'({stored_reg[`RCR_BIT_KIND_UPPER], ^stored_reg[`RCR_BIT_KIND_UPPER:`RCR_BIT_KIND_G]});

  always_comb
  begin
    unique case ({stored_reg[`RCR_BIT_TRAIN_HI], stored_reg[`RCR_BIT_TRAIN_LO]})
      2'b01:   need = 4'h2;
      2'b10:   need = 4'h4;
      2'b11:   need = 4'h8;
      2'b00:   need = 4'h1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data are taken in either order, one write and one read at a time.
  always_comb
  begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    stored_next  = stored_reg;
    timing_next  = timing_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg)
    begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = 2'h0;
      if (awaddr_reg[AXI_ADDR_W-1:4] != '0)
        bresp_next = 2'h2;
      else if (awaddr_reg[3:0] == `RCR_OFS_STORED)
      begin
        for (int i = 0; i < 4; i++)
          if (wstrb_reg[i])
            stored_next[i*8 +: 8] = wdata_reg[i*8 +: 8];
        stored_next[31] = 1'b0;
      end
      else if (awaddr_reg[3:0] == `RCR_OFS_TIMING)
      begin
        for (int i = 0; i < 4; i++)
          if (wstrb_reg[i])
            timing_next[i*8 +: 8] = wdata_reg[i*8 +: 8];
      end
      else if (awaddr_reg[3:0] != `RCR_OFS_STATUS && awaddr_reg[3:0] != `RCR_OFS_LAST_CODE)
        bresp_next = 2'h2;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next  = 2'h0;
      rdata_next  = 32'h0000_0000;
      if (s_axi_araddr[AXI_ADDR_W-1:4] != '0)
        rresp_next = 2'h2;
      else
        unique case (s_axi_araddr[3:0])
          `RCR_OFS_STORED:    rdata_next = stored_reg;
          `RCR_OFS_TIMING:    rdata_next = timing_reg;
          `RCR_OFS_STATUS:    rdata_next = status_w;
          `RCR_OFS_LAST_CODE: rdata_next = {7'h00, shift_reg};
          default:            rresp_next = 2'h2;
        endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready  = !w_have_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign status_w = {24'h000000, matched_last_reg, win_reg, count_reg, rx_on, ~drive_low_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator divider: one tick every TIMING[31:16]+1 cycles stands in for the RC oscillator.
  always_comb
  begin
    div_next = (div_reg >= timing_reg[31:16]) ? 16'h0000 : div_reg + 16'h0001;
  end
  assign osc_tick = (div_reg >= timing_reg[31:16]);

  rcr_pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    ({time_pin, code_in_pin}),
    .level_out (pins_sync)
  );

  // Same decoder for normal and demodulated input
  rcr_symbol_dec u_dec (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .osc_tick   (osc_tick),
    .code_level (pins_sync[0]),
    .invert     (stored_reg[`RCR_BIT_POLARITY]),
    .enable     (rx_on),
    .thresh     (timing_reg[15:0]),
    .sym        (sym.src)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame assembly; match_reg pulses for one cycle at the end of a correct code.
  always_comb
  begin
    shift_next        = shift_reg;
    nbit_next         = nbit_reg;
    match_next        = 1'b0;
    matched_last_next = matched_last_reg;
    if (sym.sym_abort || !rx_on)
      nbit_next = 5'h00;
    else if (sym.sym_valid)
    begin
      shift_next = {shift_reg[23:0], sym.sym_bit};
      if (nbit_reg == 5'(`RCR_FRAME_BITS - 1))
      begin
        nbit_next = 5'h00;
        match_next = ({shift_reg[23:0], sym.sym_bit} ==
                      {`RCR_SYNC_PATTERN, stored_reg[`RCR_CODE_BITS-1:0]});
        matched_last_next = match_next;
      end
      else
        nbit_next = nbit_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Window open while timing level high
  always_comb
  begin
    win_next   = pins_sync[1];
    count_next = count_reg;
    if (!win_reg)
      count_next = 4'h0;
    else if (match_reg && count_reg != 4'h8)
      count_next = count_reg + 4'h1;
  end
  assign win_end = win_reg && !pins_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage: pulse timing for single and train kinds, toggle for the toggle kind.
  always_comb
  begin
    len         = 22'(`RCR_VTR_LEN_MULT) * {6'h00, sym.sym_unit};
    st_next     = st_reg;
    cnt_next    = cnt_reg;
    toggle_next = toggle_reg;
    if (!rx_on || kind == RCR_KIND_NONE)
      st_next = RCR_OUT_IDLE;
    else if (kind == RCR_KIND_SINGLE && match_reg)
    begin
      if (st_reg == RCR_OUT_PULSE)
        cnt_next = len + 22'(`RCR_VTR_DELAY_TICKS);
      else
      begin
        st_next  = RCR_OUT_DELAY;
        cnt_next = 22'(`RCR_VTR_DELAY_TICKS);
      end
    end
    else if (kind == RCR_KIND_TRAIN && win_end && count_reg >= need)
    begin
      st_next  = RCR_OUT_PULSE;
      cnt_next = len;
    end
    else if (osc_tick)
    begin
      unique case (st_reg)
        RCR_OUT_IDLE:  st_next = RCR_OUT_IDLE;
        RCR_OUT_DELAY:
        begin
          cnt_next = cnt_reg - 22'h000001;
          if (cnt_reg == 22'h000001)
          begin
            st_next  = RCR_OUT_PULSE;
            cnt_next = len;
          end
        end
        RCR_OUT_PULSE:
        begin
          cnt_next = cnt_reg - 22'h000001;
          if (cnt_reg <= 22'h000001)
            st_next = RCR_OUT_IDLE;
        end
      endcase
    end
    if (kind == RCR_KIND_TOGGLE && rx_on && win_end && count_reg >= need)
      toggle_next = !toggle_reg;
    want_high      = (kind == RCR_KIND_TOGGLE) ? toggle_reg : (st_reg == RCR_OUT_PULSE);
    drive_low_next = rx_on && !want_high;
  end

  assign out_pin_o  = 1'b0;
  assign out_pin_oe = drive_low_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // All state registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stored_reg       <= `RCR_STORED_RST;
      timing_reg       <= `RCR_TIMING_RST;
      aw_have_reg      <= 1'b0;
      w_have_reg       <= 1'b0;
      awaddr_reg       <= '0;
      wdata_reg        <= 32'h0000_0000;
      wstrb_reg        <= 4'h0;
      bvalid_reg       <= 1'b0;
      bresp_reg        <= 2'h0;
      rvalid_reg       <= 1'b0;
      rresp_reg        <= 2'h0;
      rdata_reg        <= 32'h0000_0000;
      div_reg          <= 16'h0000;
      shift_reg        <= 25'h0000000;
      nbit_reg         <= 5'h00;
      match_reg        <= 1'b0;
      matched_last_reg <= 1'b0;
      win_reg          <= 1'b0;
      count_reg        <= 4'h0;
      st_reg           <= RCR_OUT_IDLE;
      cnt_reg          <= 22'h000000;
      toggle_reg       <= 1'b1;
      drive_low_reg    <= 1'b0;
    end
    else
    begin
      stored_reg       <= stored_next;
      timing_reg       <= timing_next;
      aw_have_reg      <= aw_have_next;
      w_have_reg       <= w_have_next;
      awaddr_reg       <= awaddr_next;
      wdata_reg        <= wdata_next;
      wstrb_reg        <= wstrb_next;
      bvalid_reg       <= bvalid_next;
      bresp_reg        <= bresp_next;
      rvalid_reg       <= rvalid_next;
      rresp_reg        <= rresp_next;
      rdata_reg        <= rdata_next;
      div_reg          <= div_next;
      shift_reg        <= shift_next;
      nbit_reg         <= nbit_next;
      match_reg        <= match_next;
      matched_last_reg <= matched_last_next;
      win_reg          <= win_next;
      count_reg        <= count_next;
      st_reg           <= st_next;
      cnt_reg          <= cnt_next;
      toggle_reg       <= toggle_next;
      drive_low_reg    <= drive_low_next;
    end
  end
endmodule // rcr_top

//--- include/rcr_cfg.svh
// Constants for the remote code receiver: offsets, fields, reset values and timing counts.
`ifndef RCR_CFG_SVH
`define RCR_CFG_SVH

// Register byte offsets.
`define RCR_OFS_STORED      4'h0
`define RCR_OFS_TIMING      4'h4
`define RCR_OFS_STATUS      4'h8
`define RCR_OFS_LAST_CODE   4'hC

// Stored word layout: code C1..C22 in bits 21..0 (C1 first received), configuration above.
`define RCR_CODE_BITS       22
`define RCR_STORED_BITS     31
`define RCR_BIT_ROLE        22
`define RCR_BIT_SIGNALLING  23
`define RCR_BIT_TX_REPEAT   24
`define RCR_BIT_TRAIN_LO    25
`define RCR_BIT_TRAIN_HI    26
`define RCR_BIT_FRONT_END   27
`define RCR_BIT_KIND_G      28
`define RCR_BIT_KIND_UPPER  29
`define RCR_BIT_POLARITY    30
`define RCR_SYNC_PATTERN    3'h2
`define RCR_FRAME_BITS      25

// Reset values.
`define RCR_STORED_RST      32'h0000_0000
`define RCR_TIMING_RST      32'h0008_0003

// Timing: delay in oscillator ticks, pulse length as unit multiple, gap as shift.
`define RCR_VTR_DELAY_TICKS 304
`define RCR_VTR_LEN_MULT    48
`define RCR_GAP_SHIFT       3

`endif

//--- include/rcr_pkg.sv
// Types shared by the remote code receiver modules.
package rcr_pkg;

  // Output stage of the single-match and train receivers.
  typedef enum logic [1:0] {
    RCR_OUT_IDLE,
    RCR_OUT_DELAY,
    RCR_OUT_PULSE
  } rcr_out_state_t;

  // Receiver kind selected by the two kind bits.
  typedef enum logic [1:0] {
    RCR_KIND_TOGGLE,
    RCR_KIND_SINGLE,
    RCR_KIND_TRAIN,
    RCR_KIND_NONE
  } rcr_kind_t;

endpackage

//--- include/rcr_sym_if.sv
// Symbol stream from the pulse classifier to the frame logic.
`timescale 1ns/1ps
interface rcr_sym_if;
  logic        sym_valid;
  logic        sym_bit;
  logic        sym_abort;
  logic [15:0] sym_unit;

  modport src (output sym_valid, output sym_bit, output sym_abort, output sym_unit);
  modport dst (input sym_valid, input sym_bit, input sym_abort, input sym_unit);
endinterface

//--- hdl/rcr_pin_sync.sv
// Three-stage pin synchroniser; a change is accepted once stages two and three agree.
`timescale 1ns/1ps
module rcr_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  if (WIDTH < 1)
  begin : g_chk
    $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Hold the old level while the last two stages disagree.
  always_comb
  begin
    level_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (level_reg & (s2_reg ^ s3_reg));
  end

  // The first stage feeds only the second, so metastability has a full cycle to settle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end
    else
    begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule // rcr_pin_sync

//--- hdl/rcr_symbol_dec.sv
// Pulse-width classifier: turns high pulses into one or zero symbols on oscillator ticks.
`timescale 1ns/1ps
`include "rcr_cfg.svh"
module rcr_symbol_dec (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        osc_tick,
  input  wire logic        code_level,
  input  wire logic        invert,
  input  wire logic        enable,
  input  wire logic [15:0] thresh,
  rcr_sym_if.src           sym
);
  logic        lvl_reg;
  logic        lvl_next;
  logic [15:0] high_reg;
  logic [15:0] high_next;
  logic [18:0] low_reg;
  logic [18:0] low_next;
  logic [15:0] unit_reg;
  logic [15:0] unit_next;
  logic        valid_reg;
  logic        valid_next;
  logic        bit_reg;
  logic        bit_next;
  logic        abort_reg;
  logic        abort_next;
  logic        cur;
  logic [18:0] gap;

  ////////////////////////////////////////////////////////////////////////////////
  // Measure high and low times; a falling edge closes a symbol, a long low drops the frame.
  always_comb
  begin
    cur        = code_level ^ invert;
    gap        = {3'h0, thresh} << `RCR_GAP_SHIFT;
    lvl_next   = lvl_reg;
    high_next  = high_reg;
    low_next   = low_reg;
    unit_next  = unit_reg;
    valid_next = 1'b0;
    bit_next   = bit_reg;
    abort_next = 1'b0;
    if (!enable)
    begin
      high_next = 16'h0000;
      low_next  = 19'h00000;
      lvl_next  = 1'b0;
    end
    else if (osc_tick)
    begin
      lvl_next = cur;
      if (cur)
      begin
        low_next = 19'h00000;
        if (high_reg != 16'hFFFF)
          high_next = high_reg + 16'h0001;
      end
      else
      begin
        if (lvl_reg)
        begin
          valid_next = 1'b1;
          bit_next   = (high_reg <= thresh);
          if (high_reg <= thresh)
            unit_next = high_reg;
          high_next = 16'h0000;
        end
        if (low_reg != 19'h7FFFF)
          low_next = low_reg + 19'h00001;
        // A line that stays low past the gap ends any partial frame.
        if (low_reg == gap)
          abort_next = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lvl_reg   <= 1'b0;
      high_reg  <= 16'h0000;
      low_reg   <= 19'h00000;
      unit_reg  <= 16'h0001;
      valid_reg <= 1'b0;
      bit_reg   <= 1'b0;
      abort_reg <= 1'b0;
    end
    else
    begin
      lvl_reg   <= lvl_next;
      high_reg  <= high_next;
      low_reg   <= low_next;
      unit_reg  <= unit_next;
      valid_reg <= valid_next;
      bit_reg   <= bit_next;
      abort_reg <= abort_next;
    end
  end

  assign sym.sym_valid = valid_reg;
  assign sym.sym_bit   = bit_reg;
  assign sym.sym_abort = abort_reg;
  assign sym.sym_unit  = unit_reg;
endmodule // rcr_symbol_dec

//--- bench/rcr_tx_model.sv
// Behavioural code transmitter that drives the receiver's code pin.
`timescale 1ns/1ps
module rcr_tx_model (
  input  wire logic aclk,
  input  wire logic invert,
  output logic      code_o
);
  logic level = 1'b0;

  // An inverting link flips every level; idle is the driven low level.
  assign code_o = level ^ invert;

  ////////////////////////////////////////////////////////////////////////
  // unmodulated normal signalling
  // Carrier removed before the pin, plain levels.
  task automatic send(input logic [21:0] code, input int unit);
    logic [24:0] frame;
    frame = {3'b010, code};
    for (int i = 24; i >= 0; i--)
    begin
      level <= 1'b1;
      repeat (frame[i] ? unit : 7 * unit) @(posedge aclk);
      level <= 1'b0;
      repeat (unit) @(posedge aclk);
    end
  endtask
endmodule // rcr_tx_model

//--- bench/rcr_top_properties.sv
// Port-level checks of the remote code receiver top.
`timescale 1ns/1ps
module rcr_top_properties #(
  parameter int AXI_ADDR_W = 12
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  code_in_pin,
  input wire logic                  time_pin,
  input wire logic                  out_pin_o,
  input wire logic                  out_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The open-drain pin may only ever pull low.
  a_od_data_low: assert property (out_pin_o == 1'b0) else $error("open-drain data not low");
  a_oe_after_reset: assert property ($rose(aresetn) |-> !out_pin_oe) else $error("pin driven after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two edges later");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[AXI_ADDR_W-1:4] != 0
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");

  // Main scenarios reached.
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_slverr: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
  c_release: cover property ($fell(out_pin_oe));
endmodule // rcr_top_properties

bind rcr_top rcr_top_properties #(.AXI_ADDR_W(AXI_ADDR_W)) rcr_top_properties_inst (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .code_in_pin, .time_pin, .out_pin_o, .out_pin_oe);

//--- bench/tb.sv
// Self-checking bench for the remote code receiver.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import rcr_pkg::*;
  localparam logic [21:0] CODE = 22'h2A5A5C;
  localparam int UNIT = 7;
  localparam int PULSE = 48 * UNIT;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] resp;} rcr_row_t;
  rcr_row_t rows [5] = '{'{12'h000, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 2'h0},
    '{12'h004, 32'h0000_0014, 32'h0000_0014, 2'h0}, '{12'h010, 32'h0000_0001, 32'h0000_0000, 2'h2},
    '{12'h008, 32'h0000_0000, 32'h0000_0081, 2'h0}, '{12'h00C, 32'h0000_0000, 32'h00AA_5A5C, 2'h0}};
  logic aclk = 0, aresetn = 0, time_pin = 0, inv = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, out_pin_o, out_pin_oe, code_in_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_errors = 0, checks = 0, cyc = 0, n;

  rcr_top #(.AXI_ADDR_W(12)) rcr_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .code_in_pin, .time_pin, .out_pin_o, .out_pin_oe);
  rcr_tx_model rcr_tx_model_inst (.aclk, .invert(inv), .code_o(code_in_pin));

  ////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns and a cycle ceiling well above the expected run.
  always #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master tasks; each channel is released only at its own handshake.
  task automatic wr(input logic [11:0] a, input logic [31:0] dw, output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dw;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) aw_ok = 1;
      if (s_axi_wready && s_axi_wvalid) w_ok = 1;
      if (aw_ok) s_axi_awvalid <= 0;
      if (w_ok) s_axi_wvalid <= 0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] dr, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    dr = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  // Stored word with normal signalling, transmit bits clear and our code.
  function automatic logic [31:0] cfg(input logic g, u, lo, hi, p);
    return {1'b0, p, u, g, 1'b0, hi, lo, 1'b0, 1'b1, 1'b0, CODE};
  endfunction

  // Counts cycles until the enable shows the wanted level, at most lim.
  task automatic meas(input logic v, input int lim, output int c);
    c = 0;
    while (out_pin_oe !== v && c < lim)
    begin
      @(posedge aclk);
      c++;
    end
  endtask

  // One timing window holding n frames; the pin may not move before its end.
  task automatic win(input int nf, input logic e);
    time_pin <= 1;
    repeat (nf) rcr_tx_model_inst.send(CODE, UNIT);
    repeat (20) @(posedge aclk);
    `CHK("held in window", e, out_pin_oe)
    time_pin <= 0;
    repeat (30) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: toggle kind with our code, registers, then the single and train kinds.
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    `CHK("oe in reset", 1'b0, out_pin_oe)
    wr(12'h000, cfg(0, 0, 0, 0, 0), r);
    rd(12'h004, d, r);
    `CHK("timing reset", 32'h0008_0003, d)
    wr(12'h004, 32'h0000_0014, r);
    win(1, 1'b0);
    `CHK("toggle on", 1'b1, out_pin_oe)
    win(1, 1'b1);
    `CHK("toggle off", 1'b0, out_pin_oe)
    $display("toggle test done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w, r);
      `CHK("bresp", rows[i].resp, r)
      rd(rows[i].a, d, r);
      `CHK("rresp", rows[i].resp, r)
      `CHK("rdata", rows[i].r, d)
    end
    $display("register test done");
    wr(12'h000, cfg(1, 0, 0, 0, 0), r);
    rcr_tx_model_inst.send(CODE, UNIT);
    meas(1'b0, 400, n);
    `CHK("pulse delay", 1'b1, n >= 295 && n <= 312)
    meas(1'b1, 400, n);
    `CHK("pulse length", PULSE, n)
    rcr_tx_model_inst.send(CODE ^ 22'h000001, UNIT);
    repeat (400) @(posedge aclk);
    `CHK("wrong code", 1'b1, out_pin_oe)
    wr(12'h000, cfg(1, 0, 0, 0, 0) | 32'h0040_0000, r);
    rcr_tx_model_inst.send(CODE, UNIT);
    repeat (400) @(posedge aclk);
    `CHK("transmit role", 1'b0, out_pin_oe)
    inv <= 1;
    wr(12'h000, cfg(1, 0, 0, 0, 1), r);
    repeat (300) @(posedge aclk);
    rcr_tx_model_inst.send(CODE, UNIT);
    meas(1'b0, 400, n);
    `CHK("inverted match", 1'b1, n >= 295 && n <= 312)
    meas(1'b1, 400, n);
    `CHK("inverted length", PULSE, n)
    $display("single test done");
    // The link stays inverting, so the trains keep the polarity bit set.
    for (int k = 1; k < 4; k++)
    begin
      wr(12'h000, cfg(1, 1, k[0], k[1], 1), r);
      win((1 << k) - 1, 1'b1);
      `CHK("short train", 1'b1, out_pin_oe)
      win(1 << k, 1'b1);
      meas(1'b0, 40, n);
      `CHK("train pulse", 1'b0, out_pin_oe)
      repeat (400) @(posedge aclk);
    end
    $display("train test done");
    conclude();
  end
endmodule // tb
